//--- hw/pae_alarm_eval.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pae_alarm_eval
    import pae_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_CYCLES
) (
    input  wire logic          CLK_IN,
    input  wire logic          NRST_IN,
    input  wire logic          PSEL_IN,
    input  wire logic          PENABLE_IN,
    input  wire logic          PWRITE_IN,
    input  wire logic [AW-1:0] PADDR_IN,
    input  wire logic [31:0]   PWDATA_IN,
    output logic      [31:0]   PRDATA_OUT,
    output logic               PREADY_OUT,
    output logic               PSLVERR_OUT,
    input  wire logic [VW-1:0] PV_IN,
    input  wire logic [VW-1:0] RAMP_SP_IN,
    input  wire logic [VW-1:0] TARGET_SP_IN,
    input  wire logic [VW-1:0] MV_HEAT_IN,
    input  wire logic [VW-1:0] MV_COOL_IN,
    input  wire logic          ANALOG_INPUT_IN,
    input  wire logic          LEVEL_ENTRY_IN,
    input  wire logic          FUNCTION_KEY_IN,
    input  wire logic          EVENT_IN,
    output logic      [NA-1:0] ALARM_OUT,
    output logic               SAMPLE_TICK_OUT
);
    localparam int TW = $clog2(SAMPLE_CYC);

    typedef struct packed {
        logic [TW-1:0]            tick_cnt;
        logic                     tick;
        logic                     aux1_heater;
        logic [NA-1:0]            assign_en;
        logic                     sp_target;
        logic                     restart_b;
        logic                     heat_cool;
        logic [RPW-1:0]           rate_period;
        logic [NA-1:0][TYW-1:0]   typ;
        logic [NA-1:0]            latch_en;
        logic [NA-1:0][VW-1:0]    value;
        logic [NA-1:0][VW-1:0]    upper;
        logic [NA-1:0][VW-1:0]    lower;
        logic [NA-1:0][VW-1:0]    hys;
        logic [NA-1:0]            hys_set;
        logic [NA-1:0]            above;
        logic [NA-1:0]            below;
        logic [NA-1:0]            standby;
        logic [NA-1:0]            out;
        logic [VW-1:0]            last_target;
        logic                     key_q;
        logic                     evt_q;
        logic [31:0]              prdata;
    } pae_state_t;

    pae_state_t st;
    pae_state_t next_st;

    logic               key_s;
    logic               evt_s;
    logic signed [EW-1:0] delta;
    logic [NA-1:0]      raw;
    logic [NA-1:0]      nxt_above;
    logic [NA-1:0]      nxt_below;
    logic [NA-1:0]      sb_type;
    logic [NA-1:0]      en;
    logic [NA-1:0][VW-1:0] hys_eff;

    // decode signals
    logic [AW-1:0]        a_off;
    logic                 is_alm;
    logic                 hit;
    logic                 wr;
    logic [AIW-1:0]       ai;
    logic [ALM_SHIFT-1:0] sub;
    logic [31:0]          rd;

    // key and event pins from outside pass two flops first
    pae_sync u_key_sync (
        .clk_in  (CLK_IN),
        .nrst_in (NRST_IN),
        .d_in    (FUNCTION_KEY_IN),
        .q_out   (key_s)
    );

    pae_sync u_evt_sync (
        .clk_in  (CLK_IN),
        .nrst_in (NRST_IN),
        .d_in    (EVENT_IN),
        .q_out   (evt_s)
    );

    // pv rate of change over the programmed period
    pae_rate u_rate (
        .clk_in    (CLK_IN),
        .nrst_in   (NRST_IN),
        .tick_in   (st.tick),
        .pv_in     (PV_IN),
        .period_in (st.rate_period),
        .delta_out (delta)
    );

    // per-alarm quantity, limits and hysteresis compare
    for (genvar g = 0; g < NA; g++) begin : g_alm
        logic [TYW-1:0]       t;
        logic signed [EW-1:0] x;
        logic signed [EW-1:0] hi;
        logic signed [EW-1:0] lo;
        logic signed [EW-1:0] hy;
        logic signed [EW-1:0] sp;
        logic                 up_k;
        logic                 lo_k;
        logic                 out_k;
        logic                 in_k;
        logic                 dev_k;
        logic                 mv_k;
        logic                 neg;
        logic                 na;
        logic                 nb;
        logic                 ovl;

        always_comb begin
            t     = st.typ[g];
            up_k  = t inside {T_UP, T_UP_SB, T_ABS_UP, T_ABS_UP_SB,
                              T_RATE, T_SP_UP, T_MV_UP};
            lo_k  = t inside {T_LO, T_LO_SB, T_ABS_LO, T_ABS_LO_SB,
                              T_SP_LO, T_MV_LO};
            out_k = t inside {T_UPLO, T_UPLO_SB};
            in_k  = (t == T_RANGE);
            dev_k = t inside {[T_UPLO:T_LO_SB]};
            mv_k  = t inside {T_MV_UP, T_MV_LO};
            neg   = st.value[g][VW-1];
            sp    = EW'(signed'(RAMP_SP_IN));
            x     = EW'(signed'(PV_IN));
            hi    = EW'(signed'(st.value[g]));
            lo    = EW'(signed'(st.value[g]));
            if (dev_k) begin
                if (out_k || in_k) begin
                    hi = sp + EW'(signed'(st.upper[g]));
                    lo = sp - EW'(signed'(st.lower[g]));
                end else begin
                    hi = sp + EW'(signed'(st.value[g]));
                    lo = sp - EW'(signed'(st.value[g]));
                end
            end
            if (t == T_RATE) begin
                x  = neg ? -delta : delta;
                hi = neg ? -hi : hi;
            end
            if (t inside {T_SP_UP, T_SP_LO}) begin
                x = st.sp_target ? EW'(signed'(TARGET_SP_IN)) : sp;
            end
            if (t == T_MV_UP) begin
                x = EW'(signed'(MV_HEAT_IN));
            end
            if (t == T_MV_LO) begin
                x = st.heat_cool ? EW'(signed'(MV_COOL_IN)) :
                                   EW'(signed'(MV_HEAT_IN));
            end
            // default hysteresis until software writes one
            if (st.hys_set[g]) begin
                hy = EW'(signed'(st.hys[g]));
            end else if (mv_k) begin
                hy = signed'(HYS_MV_DEF);
            end else if (ANALOG_INPUT_IN) begin
                hy = signed'(HYS_ANALOG_DEF);
            end else begin
                hy = signed'(HYS_TEMP_DEF);
            end
            // on past the point, off only back past hysteresis
            na  = st.above[g] ? (x > hi - hy) : (x > hi);
            nb  = st.below[g] ? (x < lo + hy) : (x < lo);
            ovl = (out_k || in_k) && (hi - hy <= lo + hy);
        end

        assign nxt_above[g] = na;
        assign nxt_below[g] = nb;
        assign hys_eff[g]   = hy[VW-1:0];
        assign sb_type[g]   = t inside {T_UPLO_SB, T_UP_SB, T_LO_SB,
                                        T_ABS_UP_SB, T_ABS_LO_SB};
        assign raw[g] = !ovl && ((up_k && na) || (lo_k && nb) ||
                        (out_k && (na || nb)) ||
                        (in_k && !(na || nb)));
        assign en[g] = st.assign_en[g] && !(g == 0 && st.aux1_heater)
                       && (up_k || lo_k || out_k || in_k);
    end

    // apb address decode and read mux
    always_comb begin
        a_off  = PADDR_IN - ALM_BASE;
        is_alm = (PADDR_IN >= ALM_BASE) && (PADDR_IN < ALM_END);
        ai     = a_off[ALM_SHIFT +: AIW];
        sub    = PADDR_IN[ALM_SHIFT-1:0];
        hit    = (PADDR_IN[1:0] == 2'b00) && (is_alm ||
                 PADDR_IN inside {REG_CTRL, REG_RATE, REG_STATUS});
        wr     = PSEL_IN && PENABLE_IN && PWRITE_IN && hit;
        rd     = '0;
        if (is_alm && hit) begin // refused reads fall through to zero
            case (sub)
                ALM_TYPE: begin
                    rd[TYW-1:0]  = st.typ[ai];
                    rd[TYPE_LATCH] = st.latch_en[ai];
                end
                ALM_VALUE: begin
                    rd[VW-1:0] = st.value[ai];
                end
                ALM_LIMITS: begin
                    rd[LIM_UPPER +: VW] = st.upper[ai];
                    rd[VW-1:0]          = st.lower[ai];
                end
                default: begin
                    rd[VW-1:0] = hys_eff[ai];
                end
            endcase
        end else begin
            case (PADDR_IN)
                REG_CTRL: begin
                    rd[CTRL_AUX1]        = st.aux1_heater;
                    rd[CTRL_SPTGT]       = st.sp_target;
                    rd[CTRL_RESTART]     = st.restart_b;
                    rd[CTRL_HEATCL]      = st.heat_cool;
                    rd[CTRL_ASSIGN +: NA] = st.assign_en;
                end
                REG_RATE: begin
                    rd[RPW-1:0] = st.rate_period;
                end
                REG_STATUS: begin
                    rd[ST_OUT +: NA]     = st.out;
                    rd[ST_STANDBY +: NA] = st.standby;
                    rd[ST_ABOVE +: NA]   = st.above;
                    rd[ST_BELOW +: NA]   = st.below;
                end
                default: begin
                    rd = '0;
                end
            endcase
        end
    end

    // next state: tick, alarm evaluation, register writes
    always_comb begin
        logic clr;
        logic sp_chg;
        logic alarm;
        clr     = 1'b0;
        sp_chg  = 1'b0;
        alarm   = 1'b0;
        next_st = st;

        // 50 ms sampling tick
        if (st.tick_cnt == TW'(SAMPLE_CYC - 1)) begin
            next_st.tick_cnt = '0;
            next_st.tick     = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 1'b1;
            next_st.tick     = 1'b0;
        end

        // latch clear sources: level entry as a level, rising edges of synced key and event pins
        next_st.key_q = key_s;
        next_st.evt_q = evt_s;
        clr = LEVEL_ENTRY_IN || (key_s && !st.key_q) ||
              (evt_s && !st.evt_q);

        if (st.tick) begin
            next_st.last_target = TARGET_SP_IN;
            sp_chg = (TARGET_SP_IN != st.last_target);
        end

        for (int i = 0; i < NA; i++) begin
            if (st.tick) begin
                next_st.above[i] = en[i] && nxt_above[i];
                next_st.below[i] = en[i] && nxt_below[i];
                alarm = en[i] && raw[i] &&
                        !(sb_type[i] && st.standby[i]);
                // leaving the range ends the wait
                if (sb_type[i] && st.standby[i] && !raw[i]) begin
                    next_st.standby[i] = 1'b0;
                end
                // a new alarm wins over a clear in the same cycle
                next_st.out[i] = alarm || (st.latch_en[i] &&
                                 st.out[i] && !clr);
            end else if (clr) begin
                next_st.out[i] = 1'b0;
            end
            // restart condition a: sp change or alarm rewrite
            if (!st.restart_b && (sp_chg ||
                (wr && is_alm && ai == AIW'(i)))) begin
                next_st.standby[i] = 1'b1;
            end
        end

        // register writes at the apb access edge
        if (wr) begin
            if (is_alm) begin
                case (sub)
                    ALM_TYPE: begin
                        next_st.typ[ai]      = PWDATA_IN[TYW-1:0];
                        next_st.latch_en[ai] = PWDATA_IN[TYPE_LATCH];
                        next_st.above[ai]    = 1'b0;
                        next_st.below[ai]    = 1'b0;
                    end
                    ALM_VALUE: begin
                        next_st.value[ai] = PWDATA_IN[VW-1:0];
                    end
                    ALM_LIMITS: begin
                        next_st.upper[ai] = PWDATA_IN[LIM_UPPER +: VW];
                        next_st.lower[ai] = PWDATA_IN[VW-1:0];
                    end
                    default: begin
                        next_st.hys[ai]     = PWDATA_IN[VW-1:0];
                        next_st.hys_set[ai] = 1'b1;
                    end
                endcase
            end else begin
                case (PADDR_IN)
                    REG_CTRL: begin
                        next_st.aux1_heater = PWDATA_IN[CTRL_AUX1];
                        next_st.sp_target   = PWDATA_IN[CTRL_SPTGT];
                        next_st.restart_b   = PWDATA_IN[CTRL_RESTART];
                        next_st.heat_cool   = PWDATA_IN[CTRL_HEATCL];
                        next_st.assign_en = PWDATA_IN[CTRL_ASSIGN +: NA];
                    end
                    REG_RATE: begin
                        if (PWDATA_IN == '0) begin
                            next_st.rate_period = RATE_MIN;
                        end else if (PWDATA_IN > 32'(RATE_MAX)) begin
                            next_st.rate_period = RATE_MAX;
                        end else begin
                            next_st.rate_period = PWDATA_IN[RPW-1:0];
                        end
                    end
                    default: begin
                        next_st.rate_period = st.rate_period;
                    end
                endcase
            end
        end

        // read data captured in the setup phase
        if (PSEL_IN && !PENABLE_IN) begin
            next_st.prdata = rd;
        end
    end

    // state register with power-up values
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            st             <= '0;
            st.assign_en   <= ASSIGN_DEF;
            st.rate_period <= RATE_DEF;
            st.typ         <= {NA{T_UP}};
            st.value[0]    <= ALM1_VALUE_DEF;
            st.value[1]    <= ALM_VALUE_DEF;
            st.value[2]    <= ALM_VALUE_DEF;
            st.value[3]    <= ALM_VALUE_DEF;
            st.standby     <= '1;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign PRDATA_OUT      = st.prdata;
    assign PREADY_OUT      = 1'b1;
    assign PSLVERR_OUT     = PSEL_IN && PENABLE_IN && !hit;
    assign ALARM_OUT       = st.out;
    assign SAMPLE_TICK_OUT = st.tick;
endmodule // pae_alarm_eval
`default_nettype wire

//--- pkg/pae_pkg.sv
`default_nettype none
package pae_pkg;
    // clock and sampling
    localparam int CLK_HZ        = 25_000_000;
    localparam int SAMPLE_MS     = 50;
    localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;

    // widths
    localparam int NA  = 4;            // alarm count
    localparam int AIW = $clog2(NA);
    localparam int VW  = 16;           // value width, signed
    localparam int EW  = VW + 2;       // headroom for sums
    localparam int TYW = 5;            // alarm type code width
    localparam int RPW = 10;           // rate period width
    localparam int AW  = 12;           // apb address width

    // value scale: one lsb is 1/100 engineering unit
    localparam int SCALE = 100;
    localparam logic [VW-1:0] ALM1_VALUE_DEF = VW'(10 * SCALE);
    localparam logic [VW-1:0] ALM_VALUE_DEF  = 16'h0000;
    localparam logic [EW-1:0] HYS_TEMP_DEF   = EW'(20);  // 0.2 deg
    localparam logic [EW-1:0] HYS_ANALOG_DEF = EW'(2);   // 0.02 %fs
    localparam logic [EW-1:0] HYS_MV_DEF     = EW'(50);  // 0.50 %

    // rate-of-change period in sampling cycles
    localparam logic [RPW-1:0] RATE_DEF = 10'h014;
    localparam logic [RPW-1:0] RATE_MIN = 10'h001;
    localparam logic [RPW-1:0] RATE_MAX = 10'h3e7;

    // alarm type codes
    localparam logic [TYW-1:0] T_OFF       = 5'h00;
    localparam logic [TYW-1:0] T_UPLO      = 5'h01;
    localparam logic [TYW-1:0] T_UP        = 5'h02;
    localparam logic [TYW-1:0] T_LO        = 5'h03;
    localparam logic [TYW-1:0] T_RANGE     = 5'h04;
    localparam logic [TYW-1:0] T_UPLO_SB   = 5'h05;
    localparam logic [TYW-1:0] T_UP_SB     = 5'h06;
    localparam logic [TYW-1:0] T_LO_SB     = 5'h07;
    localparam logic [TYW-1:0] T_ABS_UP    = 5'h08;
    localparam logic [TYW-1:0] T_ABS_LO    = 5'h09;
    localparam logic [TYW-1:0] T_ABS_UP_SB = 5'h0a;
    localparam logic [TYW-1:0] T_ABS_LO_SB = 5'h0b;
    localparam logic [TYW-1:0] T_RATE      = 5'h0d;
    localparam logic [TYW-1:0] T_SP_UP     = 5'h0e;
    localparam logic [TYW-1:0] T_SP_LO     = 5'h0f;
    localparam logic [TYW-1:0] T_MV_UP     = 5'h10;
    localparam logic [TYW-1:0] T_MV_LO     = 5'h11;

    // register map
    localparam logic [AW-1:0] REG_CTRL   = 12'h000;
    localparam logic [AW-1:0] REG_RATE   = 12'h004;
    localparam logic [AW-1:0] REG_STATUS = 12'h008;
    localparam int            ALM_SHIFT  = 4;
    localparam logic [AW-1:0] ALM_BASE   = 12'h010;
    localparam logic [AW-1:0] ALM_END    = 12'h050;
    localparam logic [ALM_SHIFT-1:0] ALM_TYPE   = 4'h0;
    localparam logic [ALM_SHIFT-1:0] ALM_VALUE  = 4'h4;
    localparam logic [ALM_SHIFT-1:0] ALM_LIMITS = 4'h8;
    localparam logic [ALM_SHIFT-1:0] ALM_HYS    = 4'hc;

    // field positions
    localparam int CTRL_AUX1    = 0;
    localparam int CTRL_SPTGT   = 1;
    localparam int CTRL_RESTART = 2;
    localparam int CTRL_HEATCL  = 3;
    localparam int CTRL_ASSIGN  = 4;
    localparam int TYPE_LATCH   = 8;
    localparam int LIM_UPPER    = 16;
    localparam int ST_OUT       = 0;
    localparam int ST_STANDBY   = 4;
    localparam int ST_ABOVE     = 8;
    localparam int ST_BELOW     = 12;
    localparam logic [NA-1:0] ASSIGN_DEF = 4'hf;
endpackage
`default_nettype wire

//--- hw/pae_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pae_sync
    import pae_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic d_in,
    output logic      q_out
);
    typedef struct packed {
        logic s1;
        logic s2;
    } pae_sync_t;

    pae_sync_t st;
    pae_sync_t next_st;

    // two-flop chain, only s2 leaves
    always_comb begin
        next_st    = st;
        next_st.s1 = d_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q_out = st.s2;
endmodule // pae_sync
`default_nettype wire

//--- hw/pae_rate.sv
`timescale 1ns/1ps
`default_nettype none
module pae_rate
    import pae_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    input  wire logic                 tick_in,
    input  wire logic [VW-1:0]        pv_in,
    input  wire logic [RPW-1:0]       period_in,
    output logic signed [EW-1:0]      delta_out
);
    typedef struct packed {
        logic [RPW-1:0] cnt;
        logic [VW-1:0]  prev;
        logic [EW-1:0]  delta;
        logic           valid;
    } pae_rate_t;

    pae_rate_t st;
    pae_rate_t next_st;

    // period counter; difference taken at each period end
    always_comb begin
        next_st = st;
        if (tick_in) begin
            if (st.cnt + 1'b1 >= period_in) begin
                next_st.cnt   = '0;
                next_st.prev  = pv_in;
                next_st.valid = 1'b1;
                next_st.delta = st.valid ?
                    EW'(signed'(pv_in)) - EW'(signed'(st.prev)) :
                    '0;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign delta_out = signed'(st.delta);
endmodule // pae_rate
`default_nettype wire

//--- dv/pae_alarm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pae_alarm_chk
    import pae_pkg::*;
#(
    parameter int SAMPLE_CYC = 8
) (
    input wire logic          CLK_IN,
    input wire logic          NRST_IN,
    input wire logic          PSEL_IN,
    input wire logic          PENABLE_IN,
    input wire logic          PWRITE_IN,
    input wire logic [AW-1:0] PADDR_IN,
    input wire logic [31:0]   PRDATA_OUT,
    input wire logic          PREADY_OUT,
    input wire logic          PSLVERR_OUT,
    input wire logic [NA-1:0] ALARM_OUT,
    input wire logic          SAMPLE_TICK_OUT
);
    int   cnt;
    logic acc;
    // cycles since the last sampling tick
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) cnt <= 0;
        else cnt <= SAMPLE_TICK_OUT ? 0 : cnt + 1;
    end
    assign acc = PSEL_IN && PENABLE_IN;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // bus answer and refusals
    ready_high_a: assert property (PREADY_OUT)
        else $error("pready low");
    unaligned_err_a: assert property (
        acc && PADDR_IN[1:0] != 2'h0 |-> PSLVERR_OUT)
        else $error("unaligned access not refused");
    idle_err_a: assert property (!acc |-> !PSLVERR_OUT)
        else $error("pslverr outside access");
    refused_zero_a: assert property (
        acc && !PWRITE_IN && PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
        else $error("refused read not zero");
    rdata_hold_a: assert property (acc |=> $stable(PRDATA_OUT))
        else $error("read data moved after access");
    // sampling tick shape and rate
    tick_pulse_a: assert property (
        SAMPLE_TICK_OUT |=> !SAMPLE_TICK_OUT)
        else $error("tick longer than one cycle");
    tick_late_a: assert property (cnt <= SAMPLE_CYC)
        else $error("tick missing");
    tick_early_a: assert property (
        SAMPLE_TICK_OUT |-> cnt >= SAMPLE_CYC - 2)
        else $error("tick too early");
    alarm_on_tick_a: assert property (
        (ALARM_OUT & ~$past(ALARM_OUT)) != 4'h0 |-> $past(SAMPLE_TICK_OUT))
        else $error("alarm rose off tick");
    // main scenarios
    cover property (SAMPLE_TICK_OUT);
    cover property (acc && PSLVERR_OUT);
    cover property ($rose(ALARM_OUT[3]));
endmodule // pae_alarm_chk
bind pae_alarm_eval pae_alarm_chk #(.SAMPLE_CYC(SAMPLE_CYC)) pae_alarm_chk_i (
    .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .ALARM_OUT(ALARM_OUT),
    .SAMPLE_TICK_OUT(SAMPLE_TICK_OUT));
`default_nettype wire

//--- dv/pae_alarm_eval_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pae_alarm_eval_tb;
    import pae_pkg::*;
    logic          clk, nrst, psel, pen, pwr, lvl, fkey, evt, ana;
    logic          prdy, perr, tick;
    logic [AW-1:0] paddr;
    logic [31:0]   pwd, prd, lf;
    logic [VW-1:0] pv;
    logic [NA-1:0] alm;
    logic [32:0]   rq[$];
    logic [NA-1:0] aq[$];
    int            errors, num_checks, i;
    int            rv[3] = '{0, 1000, 999};
    // set points and mv held at zero
    pae_alarm_eval #(.SAMPLE_CYC(8)) pae_alarm_eval_i (
        .CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd),
        .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
        .PV_IN(pv), .RAMP_SP_IN(16'h0000), .TARGET_SP_IN(16'h0000),
        .MV_HEAT_IN(16'h0000), .MV_COOL_IN(16'h0000),
        .ANALOG_INPUT_IN(ana), .LEVEL_ENTRY_IN(lvl),
        .FUNCTION_KEY_IN(fkey), .EVENT_IN(evt), .ALARM_OUT(alm),
        .SAMPLE_TICK_OUT(tick));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [AW-1:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (!prdy);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // new pv, then wait until the next tick result is compared
    task automatic step(input int v, input logic [NA-1:0] e);
        @(posedge clk);
        pv <= VW'(v);
        #1 aq.push_back(e);
        repeat (40) begin
            @(posedge clk);
            #2;
            if (aq.size() == 0) break;
        end
    endtask
    task automatic clr(input int s);
        @(posedge clk);
        lvl <= (s == 0); fkey <= (s == 1); evt <= (s == 2);
        @(posedge clk);
        lvl <= 1'b0;
        repeat (4) @(posedge clk);
        fkey <= 1'b0; evt <= 1'b0;
    endtask
    // result watcher: reads at the access edge, alarms after a tick
    always @(posedge clk) begin
        if (psel && pen && !pwr && rq.size() > 0) begin
            check({perr, prd}, rq.pop_front());
        end
        if (tick && aq.size() > 0) begin
            #1 check({29'h0, alm}, {29'h0, aq.pop_front()});
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (6000) @(posedge clk);
        errors++;
        wrap_up;
    end
    initial begin
        {nrst, psel, pen, pwr, lvl, fkey, evt, ana} = 8'h00;
        paddr = 12'h000; pwd = 32'h0; pv = 16'hff9c; lf = 32'h2969;
        errors = 0; num_checks = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(12'h010, 33'h2);
        rd(12'h014, 33'd1000);
        rd(REG_RATE, 33'd20);
        rd(12'h01c, 33'd20);
        ana <= 1'b1;
        rd(12'h01c, 33'd2);
        ana <= 1'b0;
        rd(12'h0f0, {1'b1, 32'h0});
        rd(12'h012, {1'b1, 32'h0});
        for (i = 0; i < 3; i++) begin
            apb(1'b1, REG_RATE, rv[i]);
            rd(REG_RATE, (i == 0) ? 33'd1 : 33'd999);
        end
        repeat (4) begin
            lf = lfsr(lf);
            apb(1'b1, 12'h028, lf);
            rd(12'h028, {1'b0, lf});
        end
        apb(1'b1, 12'h020, 32'h10);
        rd(12'h02c, 33'd50);
        apb(1'b1, 12'h020, 32'h0);
        apb(1'b1, 12'h030, 32'h7);
        apb(1'b1, 12'h040, 32'h102);
        step(-100, 4'h0);
        step(1100, 4'h9);
        step(990, 4'h9);
        step(-100, 4'hc);
        for (i = 0; i < 3; i++) begin
            clr(i);
            step(-100, 4'h4);
            step(100, 4'h8);
            step(-100, 4'hc);
        end
        apb(1'b1, REG_CTRL, 32'hf1);
        step(1100, 4'h8);
        // rate alarm on alarm two, falling by over 0.50 per tick, latched
        apb(1'b1, REG_RATE, 32'h1);
        apb(1'b1, 12'h024, 32'hffce);
        step(1100, 4'h8);
        step(1100, 4'h8);
        apb(1'b1, 12'h020, 32'h10d);
        step(1000, 4'h8);
        step(1000, 4'ha);
        step(1000, 4'ha);
        wrap_up;
    end
endmodule // pae_alarm_eval_tb
`default_nettype wire
